// ==== bench/dpb_decode_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module dpb_decode_test;
  import dpb_pkg::*;
  localparam logic [4:0] BASE = 5'h15;
  localparam logic [7:0] EVB [8] = '{8'h40, 8'h10, 8'h04, 8'h02, 8'h01, 8'h0A, 8'h0E, 8'h0F};
  localparam logic [23:0] TAB [6] = '{24'h4C3400, 24'h4D0100, 24'h000001, 24'h00C133,
                                      24'h000134, 24'h003500};
  logic mclk, sys_rst, io_rd, io_wr, io_rdata_oe, mem_rd, mem_ack, op_start, op_illegal_ictl;
  logic irq_pending, drv_ready, drv_wprot, op_done, ready_change;
  logic [7:0] base_sw, io_addr, io_wdata, io_rdata, mem_rdata, ev;
  logic [15:0] mem_addr, buf_addr;
  logic [2:0] op_code, cmd_latch;
  logic [1:0] drive_sel, lat;
  logic [4:0] hb;
  dpb_bufdir_type buf_dir;
  logic [7:0] exp_rd [$];
  logic [23:0] exp_op [$];
  int err_count = 0;
  int checks = 0;

  dpb_decode dut (
    .mclk(mclk), .sys_rst(sys_rst), .base_sw(base_sw), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .drive_sel(drive_sel), .op_code(op_code), .buf_addr(buf_addr), .buf_dir(buf_dir),
    .op_start(op_start), .op_illegal_ictl(op_illegal_ictl), .irq_pending(irq_pending),
    .cmd_latch(cmd_latch), .drv_ready(drv_ready), .ev_write_fault(ev[0]),
    .drv_wprot(drv_wprot), .ev_overrun(ev[1]), .ev_seek_err(ev[2]), .ev_data_crc(ev[3]),
    .ev_deleted(ev[4]), .ev_id_crc(ev[5]), .ev_no_amark(ev[6]), .ev_no_dmark(ev[7]),
    .op_done(op_done), .ready_change(ready_change)
  );
  dpb_host_mem hm (
    .mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .lat(lat)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic note_err(input string m);
    err_count++;
    $display("ERROR %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [7:0] got, exp, input string m);
    checks++;
    if (got !== exp) note_err($sformatf("%s got %h want %h", m, got, exp));
  endtask
  task automatic cmp_op(input logic [23:0] got, exp);
    checks++;
    if (got !== exp) note_err($sformatf("op fields got %h want %h", got, exp));
  endtask
  always @(posedge mclk) begin
    if (io_rdata_oe === 1'b1) begin
      if (exp_rd.size() == 0) note_err("unexpected read data");
      else cmp_rd(io_rdata, exp_rd.pop_front(), "read data");
    end
    if (op_start === 1'b1) begin
      if (exp_op.size() == 0) note_err("unexpected start");
      else cmp_op({drive_sel, op_code, buf_addr, buf_dir, op_illegal_ictl}, exp_op.pop_front());
    end
  end
  task automatic complete_run;
    if (exp_rd.size() + exp_op.size() != 0) note_err("results missing");
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // host side
  // ----------------------------------------
  task automatic io(input logic wr, input logic [2:0] p, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= {hb, p};
    io_wdata <= d;
    io_wr <= wr;
    io_rd <= !wr;
    @(posedge mclk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [7:0] e);
    exp_rd.push_back(e);
    io(1'b0, p, 8'h00);
  endtask
  // mode 0 runs to completion, 1 stops it early, 2 resets the channel mid-run
  task automatic run_op(input logic [7:0] ch, ins, cnt, trk, sec, input logic [15:0] bp,
                        input logic [7:0] evs, input logic rdy, wp, drop, input int mode);
    logic [55:0] pb;
    logic [15:0] ptr;
    logic [7:0] res;
    logic wr_op, irq;
    dpb_bufdir_type dir;
    int a0;
    int n;
    ptr = 16'($urandom);
    ins[3] = ch[3];
    pb = {bp[15:8], bp[7:0], sec, trk, cnt, ins, ch};
    for (int i = 0; i < 7; i++)
      hm.mem[ptr + 16'(i)] = pb[8*i +: 8];
    wr_op = ins[2:0] inside {3'h2, 3'h6, 3'h7};
    dir = ins[2:0] == 3'h4 ? DPB_BUF_TO_MEM : ins[2:0] == 3'h2 ? DPB_BUF_FMT_PATTERN :
          wr_op ? DPB_BUF_FROM_MEM : DPB_BUF_NONE;
    res = 8'h00;
    res[3] = trk > 8'h4C || sec[5:0] == 6'h00 || sec[5:0] > 6'h34 ||
             9'(sec[5:0]) + 9'(cnt) > 9'd52;
    res[7] = !rdy || drop;
    res[5] = wp && wr_op;
    for (int i = 0; i < 8; i++)
      if (mode == 0 && evs[i] && (i != 0 || wr_op)) res = res | EVB[i];
    irq = mode == 0 && (ch[5:4] == 2'b00 || drop);
    exp_op.push_back({ins[5:4], ins[2:0], bp, dir, ch[5]});
    a0 = hm.acks;
    drv_ready <= rdy;
    drv_wprot <= wp;
    lat <= 2'($urandom);
    io(1'b1, 3'h1, ptr[7:0]);
    io(1'b1, 3'h2, ptr[15:8]);
    n = 0;
    while (op_start !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n == 100) note_err("no start");
    cmp_rd(8'(hm.acks - a0), 8'h07, "fetch count");
    if (mode == 2) begin
      io(1'b1, 3'h7, 8'h00);
      io(1'b0, 3'h3, 8'h00);
    end else begin
      if (mode == 1) io(1'b1, 3'h3, 8'h00);
      for (int i = 0; i < 8; i++) begin
        @(posedge mclk);
        ev <= evs & 8'(1 << i);
      end
      @(posedge mclk);
      ev <= 8'h00;
      ready_change <= drop;
      drv_ready <= rdy && !drop;
      @(posedge mclk);
      ready_change <= 1'b0;
      op_done <= mode == 0;
      @(posedge mclk);
      op_done <= 1'b0;
      rd(3'h0, {4'h0, 1'b1, irq, 1'b0, rdy && !drop});
      rd(3'h1, 8'h00);
      rd(3'h3, res);
      rd(3'h0, {4'h0, 1'b1, 1'b0, 1'b0, rdy && !drop});
      cmp_rd({5'h00, cmd_latch}, 8'h03, "command latch");
    end
    drv_ready <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    base_sw = {BASE, 3'h6};
    hb = BASE;
    ev = 8'h00;
    drv_ready = 1'b1;
    drv_wprot = 1'b0;
    op_done = 1'b0;
    ready_change = 1'b0;
    lat = 2'h0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    void'($urandom(46371));
    io(1'b0, 3'h3, 8'h00);
    io(1'b0, 3'h2, 8'h00);
    hb = ~BASE;
    io(1'b0, 3'h0, 8'h00);
    io(1'b1, 3'h1, 8'h00);
    io(1'b1, 3'h2, 8'h00);
    hb = BASE;
    repeat (20) @(posedge mclk);
    $display("test refusals done");
    for (int k = 0; k < 6; k++)
      run_op(8'h10, 8'h04, TAB[k][7:0], TAB[k][23:16], TAB[k][15:8], 16'(k), 8'h00,
             1'b1, 1'b0, 1'b0, 0);
    $display("test limits done");
    for (int k = 0; k < 8; k++)
      run_op({2'b00, 2'(k), 4'h0}, {2'b00, 2'(k), 1'b0, 3'(k)}, 8'h02, 8'h4C - 8'(k), 8'h05,
             16'($urandom), 8'h01, 1'b1, 1'b1, 1'b0, 0);
    $display("test opcodes done");
    for (int k = 1; k < 8; k++)
      run_op(8'h00, 8'h14, 8'h01, 8'h10, 8'h20, 16'hBEEF, 8'(1 << k), 1'b1, 1'b0, 1'b0, 0);
    run_op(8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h00, 1'b1, 1'b0, 1'b0, 0);
    run_op(8'h00, 8'h36, 8'h01, 8'h01, 8'h01, 16'h4000, 8'h00, 1'b0, 1'b0, 1'b0, 0);
    run_op(8'h10, 8'h34, 8'h01, 8'h01, 8'h01, 16'h4100, 8'h00, 1'b1, 1'b0, 1'b1, 0);
    run_op(8'h00, 8'h06, 8'h01, 8'h01, 8'h01, 16'h4200, 8'hFF, 1'b1, 1'b0, 1'b0, 1);
    run_op(8'h00, 8'h06, 8'h01, 8'h01, 8'h01, 16'h4300, 8'h00, 1'b1, 1'b0, 1'b0, 2);
    $display("test errors done");
    for (int k = 0; k < 12; k++)
      run_op(8'($urandom), 8'($urandom), 8'($urandom_range(60)), 8'($urandom_range(90)),
             8'($urandom), 16'($urandom), 8'($urandom), 1'b1, 1'($urandom), 1'b0, 0);
    $display("test random done");
    complete_run;
  end
  initial begin
    #80000;
    note_err("watchdog expired");
    complete_run;
  end
endmodule
`default_nettype wire

// ==== bench/dpb_host_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// system memory answering block fetches
// ----------------------------------------
module dpb_host_mem (
  input wire logic mclk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  input wire logic [1:0] lat
);
  logic [7:0] mem [logic [15:0]];
  int acks = 0;
  int waits = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h5A;
  end
  // off-ack cycles the bus toggles, so stale data never looks valid
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_rd && !mem_ack) begin
      waits <= waits + 1;
      if (waits >= int'(lat)) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'h00;
        waits <= 0;
        acks <= acks + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dpb_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dpb_regs.svh"
// Functional notes
// RQ1: instruction bits 5:4 select drive 0 to 3 in binary.
// RQ2: host keeps instruction word-length bit equal to channel word bit.
// RQ3: three-bit op code decodes to the eight diskette operations.
// RQ4: track byte legal from 0 to 4C hex inclusive.
// RQ5: sector is low six bits of byte five, legal 1 to 34 hex.
// RQ6: buffer address is byte six low, byte seven high.
// RQ7: reads fill buffer, writes drain it, format fetches pattern or fill.
// RQ8: result word drives data bus on read-result-byte after type 00.
// RQ9: bit 7 set when drive not ready at start or during operation.
// RQ10: bit 6 set on drive write fault during a write.
// RQ11: bit 5 set for read-only media on format and write operations.
// RQ12: bit 4 set when a drive byte request is lost.
// RQ13: bit 3 set on bad track, bad sector, or sector plus count over 52.
// RQ14: bit 2 set when head is off track after any movement.
// RQ15: host should recalibrate after a seek error.
// RQ16: bit 1 set on data field check code mismatch.
// RQ17: bit 0 set when a deleted data mark preceded the sector.
// RQ18: ID check code mismatch sets address and check code bits.
// RQ19: no address mark over a revolution sets address, seek and check bits.
// RQ20: missing data mark sets address, seek, check and deleted bits.
// RQ21: on base match, low three I/O bits decode and latch a command; code latches only on result-byte reads and non-stop writes; a reset write clears it.
// RQ22: interrupt latch holds a request until the host clears it.
// RQ23: parameter block is seven bytes at a 16-bit host pointer.
// RQ24: channel bits 5:4: 00 interrupts on, 01 completion interrupts off.
// RQ25: a new operation clears all error result bits.
module dpb_decode (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] base_sw,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic [1:0] drive_sel,
  output logic [2:0] op_code,
  output logic [15:0] buf_addr,
  output dpb_pkg::dpb_bufdir_type buf_dir,
  output logic op_start,
  output logic op_illegal_ictl,
  output logic irq_pending,
  output logic [2:0] cmd_latch,
  input wire logic drv_ready,
  input wire logic ev_write_fault,
  input wire logic drv_wprot,
  input wire logic ev_overrun,
  input wire logic ev_seek_err,
  input wire logic ev_data_crc,
  input wire logic ev_deleted,
  input wire logic ev_id_crc,
  input wire logic ev_no_amark,
  input wire logic ev_no_dmark,
  input wire logic op_done,
  input wire logic ready_change
);
  import dpb_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_write_op(input logic [2:0] opc);
    is_write_op = (opc == DPB_OP_FORMAT) || (opc == DPB_OP_WRITE) || (opc == DPB_OP_WRDEL);
  endfunction

  function automatic logic [7:0] err_bit(input int pos);
    err_bit = 8'h01 << pos;
  endfunction

  // ----------------------------------------
  // channel command decode
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_LOAD, ST_RUN} dpb_state_type;
  dpb_state_type state_reg, state_next;

  wire base_hit = (io_addr[7:3] == base_sw[7:3]);  // RQ21
  wire [2:0] port = io_addr[2:0];
  wire wr_ma_lo = base_hit && io_wr && (port == `DPB_PORT_MA_LO);
  wire wr_ma_hi = base_hit && io_wr && (port == `DPB_PORT_MA_HI);
  wire wr_stop = base_hit && io_wr && (port == `DPB_PORT_STOP);
  wire wr_rst = base_hit && io_wr && (port == `DPB_PORT_RESET);
  wire rd_stat = base_hit && io_rd && (port == `DPB_PORT_STATUS);
  wire rd_rtype = base_hit && io_rd && (port == `DPB_PORT_RTYPE);
  wire rd_rbyte = base_hit && io_rd && (port == `DPB_PORT_RBYTE);
  wire latch_cmd = rd_rbyte || (base_hit && io_wr && (port != `DPB_PORT_STOP));
  wire chan_rst = sys_rst || wr_rst;
  // a start while busy must not restart the fetch under a running operation
  wire start_ok = wr_ma_hi && (state_reg == ST_IDLE);

  logic [15:0] pb_ptr_reg;
  logic [2:0] fetch_idx_reg;
  logic [2:0] rd_idx_reg;
  logic [2:0] cmd_latch_reg;
  logic rtype_seen_reg;
  logic [7:0] result_reg;
  logic irq_reg;
  logic [7:0] chan_reg, instr_reg, count_reg, track_reg, sector_reg, blo_reg;
  logic [7:0] pb_q;

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      cmd_latch_reg <= 3'h0;
    end else if (latch_cmd) begin
      cmd_latch_reg <= port;  // RQ21
    end
  end
  assign cmd_latch = cmd_latch_reg;

  // ----------------------------------------
  // parameter block fetch
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (wr_ma_hi) state_next = ST_FETCH;
      ST_FETCH: if (mem_ack) state_next = (fetch_idx_reg == `DPB_PB_BUF_HI) ? ST_WAIT : ST_FETCH;
      // extra beat: the store's registered read lags the last byte write by one edge
      ST_WAIT: state_next = ST_LOAD;
      ST_LOAD: state_next = ST_RUN;
      ST_RUN: if (op_done || wr_stop) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  wire fetch_ack = (state_reg == ST_FETCH) && mem_ack;

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      state_reg <= ST_IDLE;
      pb_ptr_reg <= 16'h0000;
      fetch_idx_reg <= 3'h0;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (wr_ma_lo) pb_ptr_reg[7:0] <= io_wdata;  // RQ23
      if (wr_ma_hi) pb_ptr_reg[15:8] <= io_wdata;  // RQ23
      if (start_ok) begin
        fetch_idx_reg <= 3'h0;
        mem_rd <= 1'b1;
        mem_addr <= {io_wdata, pb_ptr_reg[7:0]};
      end else if (fetch_ack) begin
        fetch_idx_reg <= fetch_idx_reg + 3'h1;
        mem_rd <= (fetch_idx_reg != `DPB_PB_BUF_HI);
        mem_addr <= mem_addr + 16'h0001;  // RQ23
      end
    end
  end

  // bytes land in the store; bytes 0 to 5 also go to shadow registers for field decode
  dpb_pb_mem u_pb (
    .mclk(mclk),
    .wr_en(fetch_ack),
    .wr_addr(fetch_idx_reg),
    .wr_data(mem_rdata),
    .rd_addr(rd_idx_reg),
    .rd_data(pb_q)
  );

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      rd_idx_reg <= 3'h0;
    end else begin
      rd_idx_reg <= `DPB_PB_BUF_HI;
    end
  end

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      chan_reg <= 8'h00;
      instr_reg <= 8'h00;
      count_reg <= 8'h00;
      track_reg <= 8'h00;
      sector_reg <= 8'h00;
      blo_reg <= 8'h00;
    end else if (fetch_ack) begin
      case (fetch_idx_reg)
        `DPB_PB_CHAN: chan_reg <= mem_rdata;
        `DPB_PB_INSTR: instr_reg <= mem_rdata;
        `DPB_PB_COUNT: count_reg <= mem_rdata;
        `DPB_PB_TRACK: track_reg <= mem_rdata;
        `DPB_PB_SECTOR: sector_reg <= mem_rdata;
        `DPB_PB_BUF_LO: blo_reg <= mem_rdata;
        default: blo_reg <= blo_reg;
      endcase
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire [2:0] opc_w = instr_reg[`DPB_OPC_LSB +: 3];  // RQ3
  wire [1:0] unit_w = instr_reg[`DPB_UNIT_LSB +: 2];  // RQ1
  wire [1:0] ictl_w = chan_reg[`DPB_ICTL_LSB +: 2];
  wire [5:0] sec_w = sector_reg[5:0];  // RQ5
  // sum kept nine bits wide so a huge count cannot wrap below the limit
  wire [8:0] span_w = {3'b000, sec_w} + {1'b0, count_reg};
  wire trk_bad = track_reg > `DPB_TRACK_MAX;  // RQ4
  wire sec_bad = (sec_w == 6'h00) || ({2'b00, sec_w} > `DPB_SECTOR_MAX);
  wire span_bad = span_w > {1'b0, `DPB_SECTOR_MAX};
  wire addr_bad = trk_bad || sec_bad || span_bad;  // RQ13
  wire wr_op = is_write_op(opc_w);
  wire running = (state_reg == ST_RUN);
  wire go = (state_reg == ST_LOAD);

  dpb_bufdir_type dir_w;
  always_comb begin
    case (opc_w)  // RQ7
      DPB_OP_READ: dir_w = DPB_BUF_TO_MEM;
      DPB_OP_WRITE, DPB_OP_WRDEL: dir_w = DPB_BUF_FROM_MEM;
      DPB_OP_FORMAT: dir_w = DPB_BUF_FMT_PATTERN;
      default: dir_w = DPB_BUF_NONE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      drive_sel <= 2'b00;
      op_code <= 3'h0;
      buf_addr <= 16'h0000;
      buf_dir <= DPB_BUF_NONE;
      op_start <= 1'b0;
      op_illegal_ictl <= 1'b0;
    end else begin
      op_start <= go;
      if (go) begin
        drive_sel <= unit_w;  // RQ1
        op_code <= opc_w;  // RQ3
        buf_addr <= {pb_q, blo_reg};  // RQ6
        buf_dir <= dir_w;  // RQ7
        op_illegal_ictl <= ictl_w[1];  // RQ24
      end
    end
  end

  // ----------------------------------------
  // error result word
  // ----------------------------------------
  logic [7:0] ev_bits;
  always_comb begin
    ev_bits = 8'h00;
    if (!drv_ready) ev_bits = ev_bits | err_bit(`DPB_ERR_NRDY);  // RQ9
    if (ev_write_fault && wr_op) ev_bits = ev_bits | err_bit(`DPB_ERR_WFLT);  // RQ10
    if (drv_wprot && wr_op) ev_bits = ev_bits | err_bit(`DPB_ERR_WPROT);  // RQ11
    if (ev_overrun) ev_bits = ev_bits | err_bit(`DPB_ERR_OVR);  // RQ12
    if (ev_seek_err) ev_bits = ev_bits | err_bit(`DPB_ERR_SEEK);  // RQ14
    if (ev_data_crc) ev_bits = ev_bits | err_bit(`DPB_ERR_CRC);  // RQ16
    if (ev_deleted) ev_bits = ev_bits | err_bit(`DPB_ERR_DEL);  // RQ17
    if (ev_id_crc) ev_bits = ev_bits | 8'h0A;  // RQ18
    if (ev_no_amark) ev_bits = ev_bits | 8'h0E;  // RQ19
    if (ev_no_dmark) ev_bits = ev_bits | 8'h0F;  // RQ20
  end

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      result_reg <= `DPB_RESULT_RST;
    end else if (go) begin
      // fresh word per operation; start checks seeded here
      result_reg <= (addr_bad ? err_bit(`DPB_ERR_ADDR) : 8'h00)  // RQ25 RQ13
        | (!drv_ready ? err_bit(`DPB_ERR_NRDY) : 8'h00)  // RQ9
        | ((drv_wprot && wr_op) ? err_bit(`DPB_ERR_WPROT) : 8'h00);  // RQ11
    end else if (running) begin
      result_reg <= result_reg | ev_bits;
    end
  end

  // ----------------------------------------
  // interrupt latch and host read port
  // ----------------------------------------
  wire irq_set = running && ((op_done && (ictl_w == 2'b00)) || ready_change);  // RQ24
  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      irq_reg <= 1'b0;
    end else if (irq_set) begin
      irq_reg <= 1'b1;  // RQ22
    end else if (rd_rtype) begin
      irq_reg <= 1'b0;  // RQ22
    end
  end
  assign irq_pending = irq_reg;

  always_ff @(posedge mclk) begin
    if (chan_rst) begin
      rtype_seen_reg <= 1'b0;
      io_rdata <= 8'h00;
      io_rdata_oe <= 1'b0;
    end else begin
      if (rd_rtype) rtype_seen_reg <= 1'b1;
      io_rdata_oe <= rd_stat || rd_rtype || (rd_rbyte && rtype_seen_reg);
      if (rd_stat) io_rdata <= {4'h0, 1'b1, irq_reg, 1'b0, drv_ready};
      else if (rd_rtype) io_rdata <= `DPB_RTYPE_ERR;
      else if (rd_rbyte && rtype_seen_reg) io_rdata <= result_reg;  // RQ8
      else io_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_addr_err;  // RQ13
    @(posedge mclk) disable iff (chan_rst) go && addr_bad |=> result_reg[`DPB_ERR_ADDR];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error not flagged");  // RQ13
  property p_clear;  // RQ25
    @(posedge mclk) disable iff (chan_rst)
      go && !addr_bad && drv_ready && !drv_wprot |=> result_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("result not cleared at start");  // RQ25
  property p_rbyte;  // RQ8
    @(posedge mclk) disable iff (chan_rst)
      rd_rbyte && rtype_seen_reg |=> io_rdata_oe && io_rdata == $past(result_reg);
  endproperty
  a_rbyte: assert property (p_rbyte) else $error("result byte not returned");  // RQ8
  property p_irq_hold;  // RQ22
    @(posedge mclk) disable iff (chan_rst) irq_set |=> irq_reg;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt latch lost");  // RQ22
  property p_drive;  // RQ1
    @(posedge mclk) disable iff (chan_rst) go |=> drive_sel == $past(instr_reg[5:4]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive select wrong");  // RQ1
  property p_nrdy;  // RQ9
    @(posedge mclk) disable iff (chan_rst) running && !drv_ready |=> result_reg[7];
  endproperty
  a_nrdy: assert property (p_nrdy) else $error("not ready missed");  // RQ9
  property p_nomark;  // RQ19
    @(posedge mclk) disable iff (chan_rst) running && ev_no_amark |=> result_reg[3:1] == 3'b111;
  endproperty
  a_nomark: assert property (p_nomark) else $error("no mark combination wrong");  // RQ19
  property p_wprot;  // RQ11
    @(posedge mclk) disable iff (chan_rst)
      running && drv_wprot && !wr_op && !result_reg[5] |=> !result_reg[5];
  endproperty
  a_wprot: assert property (p_wprot) else $error("protect flagged on non-write");  // RQ11
endmodule
`default_nettype wire

// ==== rtl/dpb_pb_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
// small store for the fetched parameter block, registered read port
module dpb_pb_mem (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:7];
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ==== rtl/dpb_pkg.sv ====
package dpb_pkg;
  typedef enum logic [2:0] {
    DPB_OP_NOP, DPB_OP_SEEK, DPB_OP_FORMAT, DPB_OP_RECAL,
    DPB_OP_READ, DPB_OP_VERIFY, DPB_OP_WRITE, DPB_OP_WRDEL
  } dpb_opcode_type;
  typedef enum logic [1:0] {
    DPB_BUF_NONE, DPB_BUF_TO_MEM, DPB_BUF_FROM_MEM, DPB_BUF_FMT_PATTERN
  } dpb_bufdir_type;
endpackage

// ==== rtl/dpb_regs.svh ====
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH
// ----------------------------------------
// channel port offsets (low three address bits)
// ----------------------------------------
`define DPB_PORT_STATUS 3'h0
`define DPB_PORT_MA_LO 3'h1
`define DPB_PORT_MA_HI 3'h2
`define DPB_PORT_STOP 3'h3
`define DPB_PORT_RESET 3'h7
`define DPB_PORT_RTYPE 3'h1
`define DPB_PORT_RBYTE 3'h3
// ----------------------------------------
// parameter block layout
// ----------------------------------------
`define DPB_PB_LEN 3'h7
`define DPB_PB_CHAN 3'h0
`define DPB_PB_INSTR 3'h1
`define DPB_PB_COUNT 3'h2
`define DPB_PB_TRACK 3'h3
`define DPB_PB_SECTOR 3'h4
`define DPB_PB_BUF_LO 3'h5
`define DPB_PB_BUF_HI 3'h6
// ----------------------------------------
// field positions and limits
// ----------------------------------------
`define DPB_OPC_LSB 0
`define DPB_WLEN_BIT 3
`define DPB_UNIT_LSB 4
`define DPB_ICTL_LSB 4
`define DPB_TRACK_MAX 8'h4C
`define DPB_SECTOR_MAX 8'h34
`define DPB_ERR_NRDY 7
`define DPB_ERR_WFLT 6
`define DPB_ERR_WPROT 5
`define DPB_ERR_OVR 4
`define DPB_ERR_ADDR 3
`define DPB_ERR_SEEK 2
`define DPB_ERR_CRC 1
`define DPB_ERR_DEL 0
`define DPB_RESULT_RST 8'h00
`define DPB_RTYPE_ERR 8'h00
`endif
